// ==== hw/hbrb_bridge.v ====
// host bus to register bridge with crossing stages, decoder and read mux
`timescale 1ns/1ps
`include "hbrb_defines.vh"

// Overview of operation
// - one command at a time, wait-request stalls
// - write captured and crossed to write port
// - address captured and crossed for both directions
// - read data crossed back onto host bus
// - register data paths are 32 bits
// - crossing logic between host and network sides
// - write strobe with address, data, lanes
// - register address counts 32-bit words
// - four lane bits mark the four bytes
// - read request holds address until valid
// - never write and read together
// - core area and local test area
// - upper address bits choose the area
// - local file ignores lanes, whole words
// - lower bits pick register, upper area
// - read valid one flip-flop after request
// - sixteen words pass through to core
module hbrb_bridge
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [12:0] host_address,
  input  wire        host_write,
  input  wire        host_read,
  input  wire [31:0] host_writedata,
  input  wire [3:0]  host_byteenable,
  output wire        host_wait_request,
  output wire [31:0] host_readdata,
  output wire        host_readdatavalid,
  output wire        reg_write_strobe,
  output wire [10:0] reg_word_addr,
  output wire [31:0] reg_write_value,
  output wire [3:0]  reg_write_lane_mask,
  output wire        reg_read_request,
  output wire        reg_read_valid,
  output wire [31:0] reg_read_value,
  output wire        core_write_strobe,
  output wire [3:0]  core_word_addr,
  output wire [31:0] core_write_value,
  output wire [3:0]  core_write_lane_mask,
  input  wire [31:0] core_read_value
);

  // -----------------------------------------------------------------
  // states
  // -----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_BUSY = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // -----------------------------------------------------------------
  // decode functions
  // -----------------------------------------------------------------
  function is_core;
    input [10:0] waddr;
    begin
      is_core = (waddr[`HBRB_AREA_HI:`HBRB_AREA_LO] == `HBRB_AREA_CORE) &&
                (waddr[`HBRB_AREA_OFF_W-1:0] < `HBRB_CORE_REGS);
    end
  endfunction

  function is_local;
    input [10:0] waddr;
    begin
      is_local = (waddr[`HBRB_AREA_HI:`HBRB_AREA_LO] == `HBRB_AREA_LOCAL) &&
                 (waddr[`HBRB_AREA_OFF_W-1:0] < `HBRB_LOCAL_REGS);
    end
  endfunction

  function [`HBRB_LOCAL_IDX_W-1:0] local_index;
    input [10:0] waddr;
    begin
      local_index = waddr[`HBRB_LOCAL_IDX_W-1:0];
    end
  endfunction

  // -----------------------------------------------------------------
  // host side
  // -----------------------------------------------------------------
  reg [2:0]  state_q;
  reg        is_write_q;
  reg [10:0] cmd_addr_q;
  reg [31:0] cmd_data_q;
  reg [3:0]  cmd_lanes_q;
  reg        req_tgl_q;
  reg        ack_s1_q;
  reg        ack_s2_q;
  reg        ack_s3_q;
  reg [31:0] host_rdata_q;
  wire       ack_edge;
  wire       cmd_take;
  // network side
  reg        req_s1_q;
  reg        req_s2_q;
  reg        req_s3_q;
  reg        net_write_q;
  reg        net_read_q;
  reg [10:0] net_addr_q;
  reg [31:0] net_data_q;
  reg [3:0]  net_lanes_q;
  reg        rd_valid_q;
  reg [31:0] rd_data_q;
  reg        ack_tgl_q;
  reg [31:0] local_q [0:`HBRB_LOCAL_REGS-1];
  reg [31:0] rd_mux;
  wire       req_edge;
  integer    i;

  assign ack_edge = ack_s2_q ^ ack_s3_q;
  assign cmd_take = (state_q == ST_IDLE) && (host_write || host_read);

  // command capture on the take edge
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      is_write_q  <= 1'b0;
      cmd_addr_q  <= 11'h000;
      cmd_data_q  <= `HBRB_ZERO_WORD;
      cmd_lanes_q <= 4'h0;
      req_tgl_q   <= 1'b0;
    end
    else if (cmd_take)
    begin
      is_write_q  <= host_write;
      cmd_addr_q  <= host_address[12:2];
      cmd_data_q  <= host_writedata;
      cmd_lanes_q <= host_byteenable;
      req_tgl_q   <= ~req_tgl_q;
    end
  end

  // read data taken from the crossing register on the acknowledge edge
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      host_rdata_q <= `HBRB_ZERO_WORD;
    end
    else if ((state_q == ST_BUSY) && ack_edge)
    begin
      host_rdata_q <= rd_data_q;
    end
  end

  // transaction state, one command at a time
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_take)
          begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (ack_edge)
          begin
            state_q      <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge synchroniser, first stage read only by the second
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end
    else
    begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  assign host_wait_request  = (state_q != ST_DONE);
  assign host_readdatavalid = (state_q == ST_DONE) && !is_write_q;
  assign host_readdata      = host_rdata_q;

  // -----------------------------------------------------------------
  // network side crossing and register interface
  // -----------------------------------------------------------------
  assign req_edge = req_s2_q ^ req_s3_q;

  // request synchroniser, first stage read only by the second
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // register port strobes and held fields
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      net_write_q <= 1'b0;
      net_read_q  <= 1'b0;
      net_addr_q  <= 11'h000;
      net_data_q  <= `HBRB_ZERO_WORD;
      net_lanes_q <= 4'h0;
    end
    else
    begin
      net_write_q <= req_edge && is_write_q;
      net_read_q  <= req_edge && !is_write_q;
      if (req_edge)
      begin
        net_addr_q  <= cmd_addr_q;
        net_data_q  <= cmd_data_q;
        net_lanes_q <= cmd_lanes_q;
      end
    end
  end

  // -----------------------------------------------------------------
  // acknowledge toggle back to the host side
  // -----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack_tgl_q <= 1'b0;
    end
    else if (net_write_q || rd_valid_q)
    begin
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  assign reg_write_strobe    = net_write_q;
  assign reg_word_addr       = net_addr_q;
  assign reg_write_value     = net_data_q;
  assign reg_write_lane_mask = net_lanes_q;
  assign reg_read_request    = net_read_q;

  // -----------------------------------------------------------------
  // decoder, core window and local register file
  // -----------------------------------------------------------------
  wire                         core_hit;
  wire                         local_hit;
  wire [`HBRB_LOCAL_IDX_W-1:0] local_idx;

  assign core_hit             = is_core(net_addr_q);
  assign local_hit            = is_local(net_addr_q);
  assign local_idx            = local_index(net_addr_q);
  assign core_write_strobe    = net_write_q && core_hit;
  assign core_word_addr       = net_addr_q[`HBRB_CORE_IDX_W-1:0];
  assign core_write_value     = net_data_q;
  assign core_write_lane_mask = net_lanes_q;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < `HBRB_LOCAL_REGS; i = i + 1)
      begin
        local_q[i] <= `HBRB_ZERO_WORD;
      end
    end
    else if (net_write_q && local_hit)
    begin
      local_q[local_idx] <= net_data_q;
    end
  end

  // read multiplexer
  always @*
  begin
    if (core_hit)
    begin
      rd_mux = core_read_value;
    end
    else if (local_hit)
    begin
      rd_mux = local_q[local_idx];
    end
    else
    begin
      rd_mux = `HBRB_ZERO_WORD;
    end
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= `HBRB_ZERO_WORD;
    end
    else
    begin
      rd_valid_q <= net_read_q;
      if (net_read_q)
      begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign reg_read_valid = rd_valid_q;
  assign reg_read_value = rd_data_q;

endmodule

// ==== pkg/hbrb_defines.vh ====
// address map, field positions and encodings for the host register bridge
`ifndef HBRB_DEFINES_VH
`define HBRB_DEFINES_VH

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define HBRB_DATA_W          32
`define HBRB_LANE_W          4
`define HBRB_BYTE_ADDR_W     13
`define HBRB_WORD_ADDR_W     11

// -----------------------------------------------------------------
// area decode on word address
// -----------------------------------------------------------------
`define HBRB_AREA_HI         10
`define HBRB_AREA_LO         6
`define HBRB_AREA_CORE       5'h00
`define HBRB_AREA_LOCAL      5'h10
`define HBRB_CORE_REGS       16
`define HBRB_CORE_IDX_W      4
`define HBRB_LOCAL_REGS      8
`define HBRB_LOCAL_IDX_W     3
`define HBRB_AREA_OFF_W      6

// -----------------------------------------------------------------
// byte offsets of the offload core window and the core and local area bounds
// -----------------------------------------------------------------
`define HBRB_CORE_RESET_CTRL      13'h0000
`define HBRB_CORE_COMMAND         13'h0004
`define HBRB_CORE_SRC_MAC_LOW     13'h0008
`define HBRB_CORE_SRC_MAC_HIGH    13'h000C
`define HBRB_CORE_DEST_IP_ADDR    13'h0010
`define HBRB_CORE_SRC_IP_ADDR     13'h0014
`define HBRB_CORE_DEST_PORT_NUM   13'h0018
`define HBRB_CORE_SRC_PORT_NUM    13'h001C
`define HBRB_CORE_TOTAL_DATA_LEN  13'h0020
`define HBRB_CORE_TIMEOUT         13'h0024
`define HBRB_CORE_PACKET_LENGTH   13'h0028
`define HBRB_CORE_PUSH_FLAG_CTRL  13'h002C
`define HBRB_CORE_WINDOW_CTRL     13'h0030
`define HBRB_CORE_PARAM_AT_34     13'h0034
`define HBRB_CORE_SERVER_MODE     13'h0038
`define HBRB_CORE_VERSION         13'h003C
`define HBRB_CORE_AREA_BASE       13'h0000
`define HBRB_CORE_AREA_LAST       13'h00FF
`define HBRB_LOCAL_AREA_BASE      13'h1000
`define HBRB_LOCAL_AREA_LAST      13'h10FF

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define HBRB_ZERO_WORD       32'h00000000

`endif

// ==== verification/hbrb_checker.sv ====
// port assertions for the host register bridge
`timescale 1ns/1ps
module hbrb_checker
(
  input logic        clk_sys,
  input logic        sys_rst,
  input logic [12:0] host_address,
  input logic        host_write,
  input logic        host_read,
  input logic [31:0] host_writedata,
  input logic [3:0]  host_byteenable,
  input logic        host_wait_request,
  input logic [31:0] host_readdata,
  input logic        host_readdatavalid,
  input logic        reg_write_strobe,
  input logic [10:0] reg_word_addr,
  input logic [31:0] reg_write_value,
  input logic [3:0]  reg_write_lane_mask,
  input logic        reg_read_request,
  input logic        reg_read_valid,
  input logic [31:0] reg_read_value,
  input logic        core_write_strobe,
  input logic [3:0]  core_word_addr,
  input logic [31:0] core_read_value
);
  logic busy_q;
  wire  take = !busy_q && (host_write || host_read);
  wire  core_hit = reg_word_addr < 11'h010;
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else if (take)
      busy_q <= 1'b1;
    else if (!host_wait_request)
      busy_q <= 1'b0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_wr_issue; ##[2:6] reg_write_strobe; endsequence
  sequence s_rd_done; ##[2:6] (host_readdatavalid && host_readdata == reg_read_value); endsequence
  property p_hold; take |=> host_wait_request[*3]; endproperty
  property p_wr; take && host_write |=> host_wait_request throughout s_wr_issue; endproperty
  property p_wr_fields;
    reg_write_strobe |-> reg_word_addr == host_address[12:2] && reg_write_value == host_writedata
      && reg_write_lane_mask == host_byteenable;
  endproperty
  property p_wr_done; reg_write_strobe |-> ##[2:6] !host_wait_request; endproperty
  property p_rd_addr; reg_read_request |-> reg_word_addr == host_address[12:2]; endproperty
  property p_rd_valid; reg_read_request |=> reg_read_valid && $stable(reg_word_addr); endproperty
  property p_no_both; !(reg_write_strobe && reg_read_request); endproperty
  property p_rd_done; reg_read_valid |-> s_rd_done; endproperty
  property p_core_wr;
    core_write_strobe == (reg_write_strobe && core_hit) && core_word_addr == reg_word_addr[3:0];
  endproperty
  property p_core_rd; reg_read_request && core_hit |=> reg_read_value == $past(core_read_value);
  endproperty
  a_hold: assert property (p_hold) else $error("wait dropped early");
  a_wr: assert property (p_wr) else $error("write not issued");
  a_wr_fields: assert property (p_wr_fields) else $error("write fields wrong");
  a_wr_done: assert property (p_wr_done) else $error("write not released");
  a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");
  a_rd_valid: assert property (p_rd_valid) else $error("read valid late");
  a_no_both: assert property (p_no_both) else $error("write and read together");
  a_rd_done: assert property (p_rd_done) else $error("read data not returned");
  a_core_wr: assert property (p_core_wr) else $error("core write decode wrong");
  a_core_rd: assert property (p_core_rd) else $error("core read mux wrong");
endmodule
bind hbrb_bridge hbrb_checker u_chk (.clk_sys, .sys_rst, .host_address, .host_write,
  .host_read, .host_writedata, .host_byteenable, .host_wait_request, .host_readdata,
  .host_readdatavalid, .reg_write_strobe, .reg_word_addr, .reg_write_value,
  .reg_write_lane_mask, .reg_read_request, .reg_read_valid, .reg_read_value,
  .core_write_strobe, .core_word_addr, .core_read_value);

// ==== verification/hbrb_core_model.sv ====
// register model of the offload core window
`timescale 1ns/1ps
module hbrb_core_model
#(
  parameter [31:0] VERSION = 32'h00000001 // arbitrary value
)
(
  input  logic        clk_sys,
  input  logic        sys_rst,
  input  logic        core_write_strobe,
  input  logic [3:0]  core_word_addr,
  input  logic [31:0] core_write_value,
  input  logic [3:0]  core_write_lane_mask,
  output logic [31:0] core_read_value
);
  logic [31:0] regs_q [0:15];
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      for (int i = 0; i < 16; i++) regs_q[i] <= 32'h0;
    else if (core_write_strobe && core_word_addr != 4'hF)
      for (int b = 0; b < 4; b++)
        if (core_write_lane_mask[b])
          regs_q[core_word_addr][8*b +: 8] <= core_write_value[8*b +: 8];
  end
  assign core_read_value = (core_word_addr == 4'hF) ? VERSION : regs_q[core_word_addr];
endmodule

// ==== verification/hbrb_bench.sv ====
// self-checking bench for the host register bridge
`timescale 1ns/1ps
module hbrb_bench;
  localparam [31:0] VER = 32'h00000001; // arbitrary value
  logic        clk_sys = 1'b0, sys_rst = 1'b1, host_write = 1'b0, host_read = 1'b0;
  logic [12:0] host_address = 13'h0000;
  logic [31:0] host_writedata = 32'h0, wd;
  logic [3:0]  host_byteenable = 4'hF, be;
  wire         host_wait_request, host_readdatavalid, reg_write_strobe, reg_read_request;
  wire         reg_read_valid, core_write_strobe;
  wire  [31:0] host_readdata, reg_write_value, reg_read_value, core_write_value, core_read_value;
  wire  [10:0] reg_word_addr;
  wire  [3:0]  reg_write_lane_mask, core_word_addr, core_write_lane_mask;
  logic [31:0] exp_q [$];
  logic [31:0] shadow [0:15];
  int          n_fail = 0, n_checks = 0;
  logic        hung = 1'b0;
  hbrb_bridge u_dut (.clk_sys, .sys_rst, .host_address, .host_write, .host_read,
    .host_writedata, .host_byteenable, .host_wait_request, .host_readdata,
    .host_readdatavalid, .reg_write_strobe, .reg_word_addr, .reg_write_value,
    .reg_write_lane_mask, .reg_read_request, .reg_read_valid, .reg_read_value,
    .core_write_strobe, .core_word_addr, .core_write_value, .core_write_lane_mask,
    .core_read_value);
  hbrb_core_model #(.VERSION(VER)) u_core (.clk_sys, .sys_rst, .core_write_strobe,
    .core_word_addr, .core_write_value, .core_write_lane_mask, .core_read_value);
  initial
    forever #50 clk_sys = ~clk_sys;
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // command held until the wait-low edge; for reads d is the expected data
  task automatic acc(input logic wr, input logic [12:0] a, input logic [31:0] d,
                     input logic [3:0] m);
    int k;
    k = 0;
    if (hung)
      return;
    host_write = wr;
    host_read = !wr;
    host_address = a;
    host_writedata = d;
    host_byteenable = m;
    if (!wr)
      exp_q.push_back(d);
    while (k < 40 && host_wait_request !== 1'b0)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 40)
    begin
      n_fail++;
      hung = 1'b1;
    end
    @(posedge clk_sys);
    #1;
  endtask
  always @(negedge clk_sys)
    if (host_readdatavalid === 1'b1)
      cmp("host_readdata", (exp_q.size() > 0) ? exp_q.pop_front() : 32'hX, host_readdata);
  initial
  begin
    wd = $urandom(32'hC2F5);
    for (int i = 0; i < 16; i++) shadow[i] = (i == 15) ? VER : 32'h0;
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      wd = $urandom;
      be = 4'($urandom);
      acc(1'b1, 13'(i * 4), wd, be);
      for (int b = 0; b < 4; b++)
        if (be[b] && i != 15) shadow[i][8*b +: 8] = wd[8*b +: 8];
      acc(1'b0, 13'(i * 4), shadow[i], 4'hF);
    end
    for (int i = 0; i < 8; i++)
    begin
      wd = $urandom;
      acc(1'b0, 13'h1000 + 13'(i * 4), 32'h0, 4'hF);
      acc(1'b1, 13'h1000 + 13'(i * 4), wd, 4'(i));
      acc(1'b0, 13'h1000 + 13'(i * 4), wd, 4'hF);
    end
    acc(1'b1, 13'h0040, wd, 4'hF);
    acc(1'b0, 13'h0040, 32'h0, 4'hF);
    acc(1'b1, 13'h1020, wd, 4'hF);
    acc(1'b0, 13'h1020, 32'h0, 4'hF);
    acc(1'b0, 13'h0008, shadow[2], 4'hF);
    host_read = 1'b0;
    repeat (4) @(posedge clk_sys);
    cmp("pending reads", 32'h0, 32'(exp_q.size()));
    print_verdict();
  end
endmodule
